// ==== mpc_map.vh ====
// register offsets, reset values and timing figures of the preset counter block
`ifndef MPC_MAP_VH
`define MPC_MAP_VH
`define MPC_REG_CTRL 5'h00
`define MPC_REG_STATUS 5'h04
`define MPC_REG_DISP 5'h08
`define MPC_REG_FLAGS 5'h0c
`define MPC_REG_ROLE 5'h10
`define MPC_CTRL_KEYLOCK 0
`define MPC_CTRL_RST 1'b0
`define MPC_TOTAL_VAL 24'h999999
`define MPC_CLK_KHZ 25000
`define MPC_IDLE_MS 60000
`define MPC_SET_MS 5000
`define MPC_HOLD_MS 3000
`define MPC_CARRY_MS 20
`define MPC_DEB_MS 5
`define MPC_BLINK_MS 250
`define MPC_TMR_UNIT_MS 360000
`define MPC_REFLASH_HALVES 4'd6
`endif

// ==== mpc_top.v ====
// nine-channel preset counter/timer control with avalon-mm status port
// How it works
// - role switches latched once after reset release
// - mode key cycles modes, 1 min idle returns
// - counting and outputs run in every mode
// - channel key or input steps selection
// - digit keys increment digit, flash; zero suppressed
// - set commits preset; 5 s then run
// - reset key or input clears selected count
// - re-monitor shows saved value, no restore
// - reset while re-monitoring restores, flashes 3 times
// - run-mode stepping skips zero-forecast channels
// - timer channels total input on time
// - decimal point flashes while input on
// - pre-forecast only shows, drives no pin
// - alarm auto-selects channel; reset clears it
// - reset+channel held 3 s clears counts
// - reset+set held 3 s clears everything
// - forecast 999999 totalizes, no stoppage output
// - totalizing counter-channel wrap gives 20 ms carry pulse, timer channels none
// - processor/storage fault codes, outputs off
// - forecast output latched until count reset
// - stoppage output latched until count reset
// - inhibit blocks counts, forces outputs off
// - channel held in reset stops, output off
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`include "mpc_map.vh"
`timescale 1ns/1ns
`default_nettype none
module mpc_top #(
  parameter [31:0] IDLE_CYC = `MPC_IDLE_MS * `MPC_CLK_KHZ,
  parameter [31:0] SET_CYC = `MPC_SET_MS * `MPC_CLK_KHZ,
  parameter [31:0] HOLD_CYC = `MPC_HOLD_MS * `MPC_CLK_KHZ,
  parameter [31:0] CARRY_CYC = `MPC_CARRY_MS * `MPC_CLK_KHZ,
  parameter [31:0] DEB_CYC = `MPC_DEB_MS * `MPC_CLK_KHZ,
  parameter [31:0] BLINK_CYC = `MPC_BLINK_MS * `MPC_CLK_KHZ,
  parameter [35:0] TMR_CYC = 36'd`MPC_TMR_UNIT_MS * 36'd`MPC_CLK_KHZ
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire keyMode,
  input wire keyChan,
  input wire keySet,
  input wire keyReset,
  input wire [5:0] keyUp,
  input wire [8:0] countIn,
  input wire chanSelIn,
  input wire resetIn,
  input wire remonIn,
  input wire inhibitIn,
  input wire [8:0] roleSel,
  input wire cpuFault,
  input wire memFault,
  output reg [8:0] forecastOut,
  output reg stopOut,
  output reg runOut,
  output reg [23:0] dispValue,
  output reg [5:0] dispBlank,
  output reg dispPoint,
  output reg [3:0] dispChan,
  output reg [1:0] dispMode,
  output reg [1:0] faultCode
);
  localparam [1:0] M_RUN = 2'd0;
  localparam [1:0] M_PRE = 2'd1;
  localparam [1:0] M_FC = 2'd2;
  localparam [1:0] M_ST = 2'd3;
  localparam [1:0] E_NONE = 2'd0;
  localparam [1:0] E_CPU = 2'd1;
  localparam [1:0] E_MEM = 2'd2;

  function [23:0] bcdInc;
    input [23:0] v;
    integer i;
    reg c;
    begin
      bcdInc = v;
      c = 1'b1;
      for (i = 0; i < 6; i = i + 1) begin
        if (c) begin
          if (v[i*4+:4] == 4'h9) begin
            bcdInc[i*4+:4] = 4'h0;
          end else begin
            bcdInc[i*4+:4] = v[i*4+:4] + 4'h1;
            c = 1'b0;
          end
        end
      end
    end
  endfunction

  function [3:0] nextCh;
    input [3:0] cur;
    input [8:0] ok;
    input skip;
    integer k;
    reg [3:0] c;
    reg done;
    begin
      nextCh = cur;
      c = cur;
      done = 1'b0;
      for (k = 0; k < 9; k = k + 1) begin
        c = (c == 4'd8) ? 4'd0 : c + 4'd1;
        if (!done && (!skip || ok[c])) begin
          nextCh = c;
          done = 1'b1;
        end
      end
    end
  endfunction

  // two-flop synchronisers; first stage read only by second
  wire [22:0] rawIn = {inhibitIn, remonIn, resetIn, chanSelIn, countIn,
    keyUp, keyReset, keySet, keyChan, keyMode};
  reg [22:0] s1Q, s2Q, smpQ, debQ, prevQ;
  reg [8:0] r1Q, r2Q, roleQ;
  reg [1:0] f1Q, f2Q, fPrevQ;
  reg roleDoneQ;
  reg [31:0] debCntQ;
  wire debTick = (debCntQ == 32'd0);
  wire [22:0] rise = debQ & ~prevQ;
  reg ctrlLockQ;
  wire [9:0] keyRise = rise[9:0] & {10{~ctrlLockQ}};
  wire [9:0] keyLvl = debQ[9:0] & {10{~ctrlLockQ}};
  wire [8:0] cntDeb = debQ[18:10];
  wire [8:0] cntRise = rise[18:10];
  wire remon = debQ[21];
  wire inhibit = debQ[22];
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      s1Q <= 23'h000000;
      s2Q <= 23'h000000;
      smpQ <= 23'h000000;
      debQ <= 23'h000000;
      prevQ <= 23'h000000;
      f1Q <= 2'h0;
      f2Q <= 2'h0;
      fPrevQ <= 2'h0;
      debCntQ <= 32'd0;
    end else begin
      s1Q <= rawIn;
      s2Q <= s1Q;
      f1Q <= {memFault, cpuFault};
      f2Q <= f1Q;
      fPrevQ <= f2Q;
      prevQ <= debQ;
      debCntQ <= debTick ? DEB_CYC - 32'd1 : debCntQ - 32'd1;
      if (debTick) begin
        smpQ <= s2Q;
        debQ <= (s2Q & smpQ) | (debQ & (s2Q | smpQ));
      end
    end
  end

  // role pins sampled through reset so release sees settled switches
  always @(posedge clk_sys) begin
    r1Q <= roleSel;
    r2Q <= r1Q;
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      roleDoneQ <= 1'b0;
      roleQ <= 9'h000;
    end else if (!roleDoneQ) begin
      roleDoneQ <= 1'b1;
      roleQ <= r2Q;
    end
  end

  // shared time bases
  reg [35:0] tmrCntQ;
  reg [31:0] blinkCntQ;
  reg blinkQ;
  wire tmrTick = (tmrCntQ == 36'd0);
  wire blinkTick = (blinkCntQ == 32'd0);
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      tmrCntQ <= 36'd0;
      blinkCntQ <= 32'd0;
      blinkQ <= 1'b0;
    end else begin
      tmrCntQ <= tmrTick ? TMR_CYC - 36'd1 : tmrCntQ - 36'd1;
      blinkCntQ <= blinkTick ? BLINK_CYC - 32'd1 : blinkCntQ - 32'd1;
      if (blinkTick) blinkQ <= ~blinkQ;
    end
  end

  reg [1:0] modeQ, errQ;
  reg [3:0] selQ;
  reg [23:0] edBufQ;
  reg [5:0] edFlashQ;
  reg edDirtyQ;
  wire errOn = (errQ != E_NONE);
  wire rstEv = keyRise[3] | rise[20];
  wire stepEv = keyRise[1] | rise[19];
  wire rstLvl = keyLvl[3] | debQ[20];
  wire setEv = keyRise[2] & (modeQ != M_RUN) & edDirtyQ;
  wire runOk = ~inhibit & ~errOn;
  wire comboA = (keyLvl[3] & keyLvl[1]) | (debQ[20] & debQ[19]);
  wire comboB = keyLvl[3] & keyLvl[2];
  reg [31:0] holdAQ, holdBQ;
  wire clrCntAll = comboA & (holdAQ == HOLD_CYC - 32'd1);
  wire clrEvery = (comboB & (holdBQ == HOLD_CYC - 32'd1)) | (f2Q[1] & ~fPrevQ[1]);
  wire [8:0] selHot = 9'h001 << selQ;
  wire singleRst = rstEv & ~remon & ~errOn;
  wire [8:0] clrCnt = (singleRst ? selHot : 9'h000) | {9{clrCntAll | clrEvery}};
  wire [8:0] restore = (rstEv & remon & ~errOn) ? selHot : 9'h000;
  wire [8:0] holdVec = rstLvl ? selHot : 9'h000;
  wire [8:0] commit = setEv ? selHot : 9'h000;
  wire [215:0] cntAll, savAll, preAll, fcAll, stAll;
  wire [8:0] preHit, fcHit, stHit, carryOn, usedVec;

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : gCh
      reg [23:0] cntQ, savQ, preQ, fcQ, stQ;
      reg fcHitQ, stHitQ, preHitQ;
      reg [31:0] carQ;
      wire tot = (fcQ == `MPC_TOTAL_VAL);
      wire adv = runOk & ~holdVec[gi] &
        (roleQ[gi] ? (cntDeb[gi] & tmrTick) : cntRise[gi]);
      always @(posedge clk_sys) begin
        if (!rst_n || clrEvery) begin
          cntQ <= 24'h000000;
          savQ <= 24'h000000;
          preQ <= 24'h000000;
          fcQ <= 24'h000000;
          stQ <= 24'h000000;
          fcHitQ <= 1'b0;
          stHitQ <= 1'b0;
          preHitQ <= 1'b0;
          carQ <= 32'd0;
        end else begin
          if (carQ != 32'd0) carQ <= carQ - 32'd1;
          if (commit[gi]) begin
            case (modeQ)
              M_PRE: preQ <= edBufQ;
              M_FC: fcQ <= edBufQ;
              M_ST: stQ <= edBufQ;
              default: preQ <= preQ;
            endcase
          end
          if (clrCnt[gi]) begin
            cntQ <= 24'h000000;
            if (!clrCntAll) savQ <= cntQ;
            fcHitQ <= 1'b0;
            stHitQ <= 1'b0;
            preHitQ <= 1'b0;
          end else begin
            if (restore[gi]) cntQ <= savQ;
            else if (adv) cntQ <= bcdInc(cntQ);
            if (adv && tot && !roleQ[gi] && cntQ == `MPC_TOTAL_VAL) carQ <= CARRY_CYC;
            if (cntQ == fcQ && fcQ != 24'h000000 && !tot) fcHitQ <= 1'b1;
            if (cntQ == stQ && stQ != 24'h000000 && !tot) stHitQ <= 1'b1;
            if (cntQ == preQ && preQ != 24'h000000 && !tot) preHitQ <= 1'b1;
          end
        end
      end
      assign cntAll[gi*24+:24] = cntQ;
      assign savAll[gi*24+:24] = savQ;
      assign preAll[gi*24+:24] = preQ;
      assign fcAll[gi*24+:24] = fcQ;
      assign stAll[gi*24+:24] = stQ;
      assign preHit[gi] = preHitQ;
      assign fcHit[gi] = fcHitQ & ~tot;
      assign stHit[gi] = stHitQ;
      assign carryOn[gi] = tot & (carQ != 32'd0);
      assign usedVec[gi] = (fcQ != 24'h000000);
    end
  endgenerate

  wire [8:0] alarmVec = preHit | fcHit | stHit;
  reg [8:0] alarmPrevQ;
  wire [8:0] alarmRise = alarmVec & ~alarmPrevQ;
  reg [3:0] autoCh;
  reg autoHit;
  integer ai;
  always @* begin
    autoCh = 4'd0;
    autoHit = 1'b0;
    for (ai = 8; ai >= 0; ai = ai - 1) begin
      if (alarmRise[ai]) begin
        autoCh = ai[3:0];
        autoHit = 1'b1;
      end
    end
  end

  reg [23:0] selPreset;
  always @* begin
    case (modeQ)
      M_PRE: selPreset = preAll[selQ*24+:24];
      M_FC: selPreset = fcAll[selQ*24+:24];
      M_ST: selPreset = stAll[selQ*24+:24];
      default: selPreset = 24'h000000;
    endcase
  end

  // operator control: mode, selection, edit, timers, faults
  reg [31:0] idleQ, setTmrQ;
  reg [3:0] reflashQ;
  integer di;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      modeQ <= M_RUN;
      errQ <= E_NONE;
      selQ <= 4'd0;
      edBufQ <= 24'h000000;
      edFlashQ <= 6'h00;
      edDirtyQ <= 1'b0;
      idleQ <= 32'd0;
      setTmrQ <= 32'd0;
      holdAQ <= 32'd0;
      holdBQ <= 32'd0;
      reflashQ <= 4'd0;
      alarmPrevQ <= 9'h000;
    end else begin
      alarmPrevQ <= alarmVec;
      holdAQ <= comboA ? ((holdAQ == HOLD_CYC - 32'd1) ? holdAQ : holdAQ + 32'd1) : 32'd0;
      holdBQ <= comboB ? ((holdBQ == HOLD_CYC - 32'd1) ? holdBQ : holdBQ + 32'd1) : 32'd0;
      if (blinkTick && reflashQ != 4'd0) reflashQ <= reflashQ - 4'd1;
      if (rstEv && remon && !errOn) reflashQ <= `MPC_REFLASH_HALVES;
      if (f2Q[1] & ~fPrevQ[1]) errQ <= E_MEM;
      else if (f2Q[0] & ~fPrevQ[0]) errQ <= E_CPU;
      else if (keyRise[3] && errOn) errQ <= E_NONE;
      if (|keyRise) idleQ <= 32'd0;
      else if (modeQ != M_RUN) idleQ <= idleQ + 32'd1;
      // post-set return, other keys cancel it
      if (setEv) setTmrQ <= SET_CYC;
      else if (|keyRise) setTmrQ <= 32'd0;
      else if (setTmrQ != 32'd0) setTmrQ <= setTmrQ - 32'd1;
      if (keyRise[0]) begin
        modeQ <= modeQ + 2'd1;
        edDirtyQ <= 1'b0;
      end else if (idleQ == IDLE_CYC - 32'd1 || setTmrQ == 32'd1) begin
        modeQ <= M_RUN;
        edDirtyQ <= 1'b0;
      end
      if (autoHit) begin
        selQ <= autoCh;
        edDirtyQ <= 1'b0;
      end else if (stepEv) begin
        selQ <= nextCh(selQ, usedVec, modeQ == M_RUN);
        edDirtyQ <= 1'b0;
      end
      if (!edDirtyQ || keyRise[0] || stepEv || autoHit) begin
        edBufQ <= selPreset;
        edFlashQ <= 6'h00;
      end
      if (modeQ != M_RUN && |keyRise[9:4] && !keyRise[0] && !stepEv && !autoHit) begin
        edDirtyQ <= 1'b1;
        for (di = 0; di < 6; di = di + 1) begin
          if (keyRise[4+di]) begin
            edFlashQ[di] <= 1'b1;
            if (edBufQ[di*4+:4] == 4'h9) edBufQ[di*4+:4] <= 4'h0;
            else edBufQ[di*4+:4] <= (edDirtyQ ? edBufQ[di*4+:4] : selPreset[di*4+:4]) + 4'h1;
          end
        end
      end
      if (setEv) edDirtyQ <= 1'b0;
    end
  end

  // display and pins
  reg [23:0] dv;
  reg [5:0] db;
  integer zi;
  always @* begin
    if (modeQ != M_RUN) dv = edDirtyQ ? edBufQ : selPreset;
    else if (remon && reflashQ == 4'd0) dv = savAll[selQ*24+:24];
    else dv = cntAll[selQ*24+:24];
    db = 6'h00;
    if (modeQ != M_RUN) begin
      for (zi = 5; zi > 0; zi = zi - 1) begin
        if ((dv >> (zi * 4)) == 24'h000000) db[zi] = 1'b1;
      end
      if (blinkQ) db = db | edFlashQ;
    end
    if (reflashQ != 4'd0 && blinkQ) db = 6'h3f;
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      forecastOut <= 9'h000;
      stopOut <= 1'b0;
      runOut <= 1'b0;
      dispValue <= 24'h000000;
      dispBlank <= 6'h00;
      dispPoint <= 1'b0;
      dispChan <= 4'd0;
      dispMode <= M_RUN;
      faultCode <= E_NONE;
    end else begin
      forecastOut <= runOk ? ((fcHit | carryOn) & ~holdVec) : 9'h000;
      stopOut <= runOk & |(stHit & ~holdVec);
      runOut <= runOk;
      dispValue <= errOn ? 24'h000000 : dv;
      dispBlank <= errOn ? 6'h3f : db;
      dispPoint <= cntDeb[selQ] & blinkQ;
      dispChan <= selQ + 4'd1;
      dispMode <= modeQ;
      faultCode <= errQ;
    end
  end

  // avalon-mm slave, one wait state per access
  reg ackQ;
  assign avs_waitrequest = (avs_read | avs_write) & ~ackQ;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ackQ <= 1'b0;
      avs_readdata <= 32'h00000000;
      ctrlLockQ <= `MPC_CTRL_RST;
    end else begin
      ackQ <= (avs_read | avs_write) & ~ackQ;
      if (avs_write && ackQ && avs_address == `MPC_REG_CTRL && avs_byteenable[0])
        ctrlLockQ <= avs_writedata[`MPC_CTRL_KEYLOCK];
      if (avs_read && !ackQ) begin
        case (avs_address)
          `MPC_REG_CTRL: avs_readdata <= {31'h00000000, ctrlLockQ};
          `MPC_REG_STATUS: avs_readdata <= {20'h00000, inhibit, remon,
            errQ, selQ, 2'h0, modeQ};
          `MPC_REG_DISP: avs_readdata <= {8'h00, dispValue};
          `MPC_REG_FLAGS: avs_readdata <= {5'h00, stHit, fcHit, preHit};
          `MPC_REG_ROLE: avs_readdata <= {23'h000000, roleQ};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // mpc_top
`default_nettype wire

// ==== mpc_checker.sv ====
// checker for the preset counter control ports
`timescale 1ns/1ns
`default_nettype none
module mpc_checker #(
  parameter [31:0] DEB_CYC = 32'd4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic keyReset,
  input wire logic [8:0] countIn,
  input wire logic resetIn,
  input wire logic inhibitIn,
  input wire logic cpuFault,
  input wire logic memFault,
  input wire logic [8:0] forecastOut,
  input wire logic stopOut,
  input wire logic runOut,
  input wire logic dispPoint,
  input wire logic [3:0] dispChan,
  input wire logic [1:0] faultCode
);
  // settle time after a debounced input, with margin
  localparam int LIM = 4 * DEB_CYC + 8;
  logic [7:0] inhCnt;
  logic [7:0] quiet;
  logic [7:0] lowCnt;
  logic [3:0] upCnt;
  logic [3:0] chanQ;
  logic selIn;
  logic clrIn;
  assign selIn = (dispChan != 4'h0) ? countIn[dispChan - 4'h1] : 1'b1;
  assign clrIn = keyReset | resetIn | inhibitIn | cpuFault | memFault;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // saturating, so long quiet spans never wrap back
  always_ff @(posedge clk_sys) begin
    chanQ <= dispChan;
    if (!rst_n) begin
      inhCnt <= 8'h00;
      quiet <= 8'h00;
      lowCnt <= 8'h00;
      upCnt <= 4'h0;
    end else begin
      upCnt <= upCnt + {3'h0, upCnt != 4'hf};
      inhCnt <= inhibitIn ? inhCnt + {7'h00, inhCnt != 8'hff} : 8'h00;
      quiet <= clrIn ? 8'h00 : quiet + {7'h00, quiet != 8'hff};
      lowCnt <= (selIn || dispChan != chanQ) ? 8'h00 : lowCnt + {7'h00, lowCnt != 8'hff};
    end
  end
  sequence sOneWait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence sFaultHeld;
    (faultCode != 2'h0) [*3];
  endsequence
  a_bus_wait: assert property ($rose(avs_read || avs_write) |-> sOneWait)
    else $error("waitrequest not low after one cycle");
  a_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_unmap_zero: assert property (
    avs_read && !avs_waitrequest && avs_address > 5'h10 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_inhibit_off: assert property (
    inhCnt > LIM |-> forecastOut == 9'h000 && !stopOut && !runOut)
    else $error("outputs on under inhibit");
  a_fault_off: assert property (
    sFaultHeld |-> forecastOut == 9'h000 && !stopOut && !runOut)
    else $error("outputs on under fault");
  a_fault_clear: assert property ($fell(faultCode != 2'h0) |-> quiet < LIM)
    else $error("fault cleared without reset");
  a_stop_hold: assert property ($fell(stopOut) |-> quiet < LIM)
    else $error("stoppage dropped without reset");
  a_point_idle: assert property (lowCnt > LIM |-> !dispPoint)
    else $error("point lit with input off");
  a_chan_range: assert property (
    upCnt > 4'h3 |-> dispChan >= 4'h1 && dispChan <= 4'h9)
    else $error("channel out of range");
endmodule // mpc_checker
bind mpc_top mpc_checker #(.DEB_CYC(DEB_CYC)) chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .keyReset(keyReset), .countIn(countIn), .resetIn(resetIn), .inhibitIn(inhibitIn),
  .cpuFault(cpuFault), .memFault(memFault), .forecastOut(forecastOut), .stopOut(stopOut),
  .runOut(runOut), .dispPoint(dispPoint), .dispChan(dispChan), .faultCode(faultCode));
`default_nettype wire

// ==== mpc_panel.sv ====
// operator key and discrete input model
`timescale 1ns/1ns
`default_nettype none
module mpc_panel (
  input wire logic clk_sys,
  output logic [22:0] lines
);
  initial lines = 23'h0;
  // held past debounce, released as long
  task automatic press(input logic [22:0] m, input int n);
    lines <= lines | m;
    repeat (n) @(posedge clk_sys);
    lines <= lines & ~m;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic level(input logic [22:0] m, input logic v);
    lines <= v ? (lines | m) : (lines & ~m);
    repeat (32) @(posedge clk_sys);
  endtask
endmodule // mpc_panel
`default_nettype wire

// ==== mpc_top_tb_top.sv ====
// self-checking bench for the preset counter control block
`timescale 1ns/1ns
`default_nettype none
module mpc_top_tb_top;
  typedef struct packed {
    logic [4:0] a; logic w; logic [31:0] d; logic [3:0] b; logic [31:0] e;
  } mpc_row_t;
  localparam logic [22:0] MODE = 23'h000001;
  localparam logic [22:0] CHAN = 23'h000002;
  localparam logic [22:0] SET = 23'h000004;
  localparam logic [22:0] RST = 23'h000008;
  localparam logic [22:0] UP0 = 23'h000010;
  localparam logic [22:0] UP5 = 23'h000200;
  localparam logic [22:0] CHSEL = 23'h000400;
  localparam logic [22:0] CNT3 = 23'h010000;
  localparam logic [22:0] RSTIN = 23'h000800;
  localparam logic [22:0] REMON = 23'h001000;
  localparam logic [22:0] INH = 23'h002000;
  localparam logic [22:0] CNT1 = 23'h004000;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] be = 4'hf;
  logic [8:0] roleSel = 9'h0a4;
  logic cpuFault = 1'b0;
  logic memFault = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [8:0] forecastOut;
  logic stopOut;
  logic runOut;
  logic [23:0] dispValue;
  logic [5:0] dispBlank;
  logic [3:0] dispChan;
  logic [1:0] dispMode;
  logic [1:0] faultCode;
  logic [31:0] rd;
  wire [22:0] ln;
  int failCount = 0;
  int numChecks = 0;
  // a write with byte 0 disabled must leave the lock bit alone
  mpc_row_t rows [7] = '{'{5'h10, 1'b0, 32'h0, 4'hf, 32'h0a4},
    '{5'h00, 1'b1, 32'h1, 4'hf, 32'h1}, '{5'h00, 1'b1, 32'h0, 4'he, 32'h1},
    '{5'h00, 1'b1, 32'h0, 4'hf, 32'h0}, '{5'h04, 1'b1, 32'hfff, 4'hf, 32'h0},
    '{5'h14, 1'b1, 32'h5, 4'hf, 32'h0}, '{5'h1c, 1'b0, 32'h0, 4'hf, 32'h0}};
  always #20 clk_sys = ~clk_sys;
  mpc_panel pnl (.clk_sys(clk_sys), .lines(ln));
  mpc_top #(.DEB_CYC(32'd4), .IDLE_CYC(32'd400), .SET_CYC(32'd200), .HOLD_CYC(32'd100),
    .CARRY_CYC(32'd20), .BLINK_CYC(32'd8), .TMR_CYC(36'd10)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .keyMode(ln[0]),
    .keyChan(ln[1]), .keySet(ln[2]), .keyReset(ln[3]), .keyUp(ln[9:4]), .countIn(ln[22:14]),
    .chanSelIn(ln[10]), .resetIn(ln[11]), .remonIn(ln[12]), .inhibitIn(ln[13]),
    .roleSel(roleSel), .cpuFault(cpuFault), .memFault(memFault), .forecastOut(forecastOut),
    .stopOut(stopOut), .runOut(runOut), .dispValue(dispValue), .dispBlank(dispBlank),
    .dispPoint(),
    .dispChan(dispChan), .dispMode(dispMode), .faultCode(faultCode));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int t;
    t = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk_sys);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 9);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (t >= 9) failCount++;
    @(posedge clk_sys);
  endtask
  task automatic pr(input logic [22:0] m, input int k);
    repeat (k) pnl.press(m, 16);
  endtask
  task automatic testDone();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // whole run needs about 2500 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    failCount++;
    testDone();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    check({21'h0, forecastOut, stopOut, runOut}, 32'h0);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    roleSel <= 9'h15a;
    check({28'h0, dispChan}, 32'h1);
    $display("test reset done");
    foreach (rows[i]) begin
      if (rows[i].w) begin
        be <= rows[i].b;
        bus(1'b1, rows[i].a, rows[i].d);
      end
      be <= 4'hf;
      bus(1'b0, rows[i].a, 32'h0);
      check(rd, rows[i].e);
    end
    $display("test registers done");
    pr(MODE, 3);
    check({30'h0, dispMode}, 32'h3);
    pr(UP0, 1);
    pr(SET, 1);
    repeat (240) @(posedge clk_sys);
    check({30'h0, dispMode}, 32'h0);
    pr(MODE, 2);
    pr(UP0, 2);
    check({8'h0, dispValue}, 32'h2);
    check({26'h0, dispBlank | 6'h01}, 32'h3f);
    pr(SET, 1);
    repeat (240) @(posedge clk_sys);
    pr(CNT1, 1);
    check({31'h0, stopOut}, 32'h1);
    pr(CNT1, 1);
    check({23'h0, forecastOut}, 32'h1);
    pr(CHAN, 1);
    check({28'h0, dispChan}, 32'h1);
    $display("test presets done");
    pnl.level(INH, 1'b1);
    check({21'h0, forecastOut, stopOut, runOut}, 32'h0);
    pr(CNT1, 1);
    pnl.level(INH, 1'b0);
    check({8'h0, dispValue}, 32'h2);
    pnl.press(RSTIN, 16);
    check({8'h0, dispValue}, 32'h0);
    check({22'h0, forecastOut, stopOut}, 32'h0);
    pnl.level(REMON, 1'b1);
    check({8'h0, dispValue}, 32'h2);
    pnl.level(REMON, 1'b0);
    check({8'h0, dispValue}, 32'h0);
    pnl.level(REMON, 1'b1);
    pr(RST, 1);
    pnl.level(REMON, 1'b0);
    check({8'h0, dispValue}, 32'h2);
    $display("test reset and recall done");
    pnl.press(SET | RST, 120);
    pr(MODE, 2);
    check({8'h0, dispValue}, 32'h0);
    repeat (440) @(posedge clk_sys);
    check({30'h0, dispMode}, 32'h0);
    $display("test clear done");
    cpuFault <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check({30'h0, faultCode}, 32'h1);
    check({21'h0, forecastOut, stopOut, runOut}, 32'h0);
    cpuFault <= 1'b0;
    pr(RST, 1);
    check({30'h0, faultCode}, 32'h0);
    memFault <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check({30'h0, faultCode}, 32'h2);
    memFault <= 1'b0;
    pr(RST, 1);
    $display("test faults done");
    // edit mode steps every channel, so the input walks to channel 3
    pr(MODE, 1);
    pnl.press(CHSEL, 16);
    pnl.press(CHSEL, 16);
    check({28'h0, dispChan}, 32'h3);
    pr(UP5, 1);
    check({8'h0, dispValue}, 32'h100000);
    pr(MODE, 3);
    // channel 3 is a timer: about ten units for a hundred cycles on
    pnl.press(CNT3, 100);
    check({31'h0, dispValue >= 24'h000009 && dispValue <= 24'h000011}, 32'h1);
    $display("test selection and timer done");
    testDone();
  end
endmodule // mpc_top_tb_top
`default_nettype wire
